// ==== rtl/overvoltage_stage_timing.sv ====
// Overvoltage stage: pick-up, blocking, operating and release timing, readouts.
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Blocking input is sampled at each processing tick before evaluation.
// - Pick-up without blocking raises start and starts the operating timer.
// - Pick-up with blocking raises blocked only; no start or timing.
// - Blocking while started drops start through the normal release handling.
// - Instant operation trips in the same tick as start.
// - Fixed delay trips after the set delay of continuous pick-up.
// - Inverse time equals dial over ratio to the exponent minus one.
// - Delay type selects fixed or inverse time, fixed by default.
// - Fixed delay in 5 ms steps, default 40 ms, zero means instant.
// - Time dial in 0.01 s steps, default 0.05 s.
// - Inverse exponent in 0.01 steps, default 1.00.
// - Release delay in 5 ms steps, default 60 ms, holds start.
// - Delayed release, default on, drops start after release delay.
// - Timer reset after release clears the timer only after full release delay.
// - Continue timing keeps the operating timer counting during release; the code does so only with timer reset after release on.
// - Remaining time to trip is reported in 5 ms units.
// - Expected operating time is reported and tracks voltage in inverse mode.
// - Ratio to threshold reported per phase and supervised quantity, 0.01 units.
// - Operating state reported as on, blocked, test, test-blocked or off.
// - Pick-up level reported in primary volts with 0.1 V resolution.
// - Pick-up drops only below 97 percent of threshold.
// - Pick-up needs one, two or three phases over threshold by mode.
// - Forcing overrides outputs to normal, start, trip or blocked.
module overvoltage_stage_timing #(
    parameter int TICK_CYCLES = ovstage_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Register port.
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Measured voltages in 0.01 %Un, three phases then supervised quantity.
    input wire logic [17:0] measured_voltage_i [4],
    // Blocking from the blocking matrix.
    input wire logic block_i,
    // Stage outputs.
    output ovstage_pkg::stage_out_t stage_o,
    output logic tick_o
);
    import ovstage_pkg::*;

    ctrl_t ctrl_reg;
    logic [17:0] uset_reg;
    logic [19:0] delay_ms_reg, release_ms_reg;
    logic [15:0] dial_reg, exp_reg;
    logic [23:0] vt_prim_reg;
    logic [31:0] tick_cnt_reg;
    logic tick;
    logic [2:0] over_reg;
    logic [17:0] ratio_reg [4];
    logic [31:0] pickup_prim_reg;
    logic [19:0] inverse_delay_mode_ticks_reg;
    eng_state_t eng_reg;
    logic [2:0] ch_reg;
    logic [4:0] pow_cnt_reg;
    logic [39:0] pow_reg;
    logic [39:0] div_n, div_d, div_q;
    logic [17:0] rmax;
    logic block_smp_reg;
    logic start_reg, trip_reg, blocked_reg, releasing_reg;
    logic [19:0] op_cnt_reg, rel_cnt_reg;
    logic [19:0] delay_ticks, rel_ticks, op_target, rel_next;
    logic [1:0] over_count;
    logic pickup, off_mode, node_block, blk_now, fixed_mode, instant, rel_expired;
    node_state_t node_state;
    force_t force_mode;
    stage_out_t out_next;

    // Processing tick divider: one pulse per 5 ms cycle.
    // Fixed tick base.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || tick) begin
            tick_cnt_reg <= 32'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
        end
    end
    assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
    assign tick_o = tick;

    // Settings writes from the register port.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ctrl_reg <= ctrl_t'(CTRL_RESET);
            uset_reg <= USET_RESET;
            delay_ms_reg <= DELAY_RESET;
            dial_reg <= DIAL_RESET;
            exp_reg <= EXP_RESET;
            release_ms_reg <= RELEASE_RESET;
            vt_prim_reg <= VT_PRIM_RESET;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                OFS_CTRL: ctrl_reg <= ctrl_t'(reg_wdata_i[15:0]);
                OFS_USET: uset_reg <= reg_wdata_i[17:0];
                OFS_DELAY: delay_ms_reg <= reg_wdata_i[19:0];
                OFS_DIAL: dial_reg <= reg_wdata_i[15:0];
                OFS_EXP: exp_reg <= reg_wdata_i[15:0];
                OFS_RELEASE: release_ms_reg <= reg_wdata_i[19:0];
                OFS_VT_PRIM: vt_prim_reg <= reg_wdata_i[23:0];
                default: ;
            endcase
        end
    end

    // Mode decoding; codes above the last state count as off.
    // Operating state decode.
    always_comb begin
        case (ctrl_reg.node_mode)
            3'h0: node_state = NODE_ON;
            3'h1: node_state = NODE_BLOCKED;
            3'h2: node_state = NODE_TEST;
            3'h3: node_state = NODE_TEST_BLOCKED;
            default: node_state = NODE_OFF;
        endcase
    end
    assign force_mode = force_t'(ctrl_reg.force_sel);
    assign off_mode = (node_state == NODE_OFF);
    assign node_block = (node_state == NODE_BLOCKED) || (node_state == NODE_TEST_BLOCKED);

    // Delays in ms rounded up to whole ticks.
    assign delay_ticks = 20'((delay_ms_reg + 20'(TICK_MS - 1)) / 20'(TICK_MS));
    assign rel_ticks = 20'((release_ms_reg + 20'(TICK_MS - 1)) / 20'(TICK_MS));
    // Delay type picks the active characteristic.
    assign fixed_mode = !ctrl_reg.inverse_delay_mode;
    // Zero fixed delay behaves as instant.
    assign instant = fixed_mode && (delay_ticks == 20'h0);
    assign op_target = fixed_mode ? delay_ticks : inverse_delay_mode_ticks_reg;

    // Phase comparators with fixed 97 percent reset ratio.
    // Hysteresis against threshold.
    for (genvar i = 0; i < 3; i++) begin : g_phase
        always_ff @(posedge sys_clk_i) begin
            if (reset_i) begin
                over_reg[i] <= 1'b0;
            end else if (tick) begin
                if (measured_voltage_i[i] > uset_reg) begin
                    over_reg[i] <= 1'b1;
                end else if (40'(measured_voltage_i[i]) * 40'd100 < 40'(uset_reg) * RESET_RATIO_PCT) begin
                    over_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Pick-up needs the chosen number of phases.
    assign over_count = 2'(over_reg[0]) + 2'(over_reg[1]) + 2'(over_reg[2]);
    assign pickup = (over_count != 2'h0) && (over_count >= ((ctrl_reg.op_mode == 2'h0) ? 2'h1 : ctrl_reg.op_mode));

    // Largest phase ratio drives the inverse characteristic.
    always_comb begin
        rmax = ratio_reg[0];
        if (ratio_reg[1] > rmax) begin
            rmax = ratio_reg[1];
        end
        if (ratio_reg[2] > rmax) begin
            rmax = ratio_reg[2];
        end
    end

    // Shared divider operand selection for the calculation engine.
    always_comb begin
        div_n = 40'h1;
        div_d = 40'h1;
        case (eng_reg)
            ENG_RATIO: begin
                div_n = 40'(measured_voltage_i[ch_reg[1:0]]) * 40'd100;
                div_d = 40'(uset_reg);
            end
            ENG_PRIM: begin
                div_n = 40'(uset_reg) * 40'(vt_prim_reg);
                div_d = 40'd10000;
            end
            ENG_POWER: begin
                div_n = pow_reg * 40'(rmax);
                div_d = 40'd100;
            end
            ENG_FRAC: begin
                div_n = pow_reg * 40'(rmax - 18'd100) * 40'(exp_reg % 16'd100);
                div_d = 40'd10000;
            end
            ENG_TIME: begin
                div_n = 40'(dial_reg) * 40'd200 + pow_reg - 40'd101;
                div_d = pow_reg - 40'd100;
            end
            default: ;
        endcase
        if (div_d == 40'h0) begin
            div_d = 40'h1;
        end
    end
    assign div_q = div_n / div_d;

    // Calculation engine: ratios, primary level, then inverse time in ticks.
    // Inverse time as dial over power of ratio minus one.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            eng_reg <= ENG_IDLE;
            ch_reg <= 3'h0;
            pow_cnt_reg <= 5'h0;
            pow_reg <= 40'd100;
            inverse_delay_mode_ticks_reg <= MAX_TICKS;
            pickup_prim_reg <= 32'h0;
            for (int j = 0; j < 4; j++) begin
                ratio_reg[j] <= 18'h0;
            end
        end else begin
            case (eng_reg)
                ENG_IDLE: begin
                    if (tick) begin
                        eng_reg <= ENG_RATIO;
                        ch_reg <= 3'h0;
                    end
                end
                ENG_RATIO: begin
                    ratio_reg[ch_reg[1:0]] <= (div_q > 40'h3ffff) ? 18'h3ffff : div_q[17:0];
                    ch_reg <= ch_reg + 3'h1;
                    if (ch_reg == 3'h3) begin
                        eng_reg <= ENG_PRIM;
                    end
                end
                // Primary pick-up level in 0.1 V.
                ENG_PRIM: begin
                    pickup_prim_reg <= div_q[31:0];
                    pow_reg <= 40'd100;
                    pow_cnt_reg <= 5'(exp_reg / 16'd100);
                    eng_reg <= ENG_POWER;
                end
                // Whole part of the exponent by repeated products.
                ENG_POWER: begin
                    if (pow_cnt_reg == 5'h0) begin
                        eng_reg <= ENG_FRAC;
                    end else begin
                        pow_reg <= (div_q > POW_CAP) ? POW_CAP : div_q;
                        pow_cnt_reg <= pow_cnt_reg - 5'h1;
                    end
                end
                // Fractional exponent by linear step; below threshold the power stays as is.
                ENG_FRAC: begin
                    if (rmax > 18'd100) begin
                        pow_reg <= pow_reg + div_q;
                    end
                    eng_reg <= ENG_TIME;
                end
                // Dial in 0.01 s; ticks rounded up, capped at 1800 s.
                ENG_TIME: begin
                    if (pow_reg <= 40'd100 || div_q >= 40'(MAX_TICKS)) begin
                        inverse_delay_mode_ticks_reg <= MAX_TICKS;
                    end else begin
                        inverse_delay_mode_ticks_reg <= div_q[19:0];
                    end
                    eng_reg <= ENG_IDLE;
                end
                default: eng_reg <= ENG_IDLE;
            endcase
        end
    end

    // Blocking taken at the start of the tick.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            block_smp_reg <= 1'b0;
        end else if (tick) begin
            block_smp_reg <= block_i;
        end
    end
    assign blk_now = block_i || node_block;

    assign rel_next = releasing_reg ? rel_cnt_reg + 20'h1 : 20'h1;
    assign rel_expired = rel_next >= rel_ticks;

    // Start, trip and release timing, evaluated once per tick.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            start_reg <= 1'b0;
            trip_reg <= 1'b0;
            blocked_reg <= 1'b0;
            releasing_reg <= 1'b0;
            op_cnt_reg <= 20'h0;
            rel_cnt_reg <= 20'h0;
        end else if (tick) begin
            // Blocked pick-up gives only the blocked output.
            blocked_reg <= pickup && blk_now && !off_mode;
            if (off_mode) begin
                start_reg <= 1'b0;
                trip_reg <= 1'b0;
                releasing_reg <= 1'b0;
                op_cnt_reg <= 20'h0;
                rel_cnt_reg <= 20'h0;
            end else if (pickup && !blk_now) begin
                // Start and run the operating timer.
                start_reg <= 1'b1;
                releasing_reg <= 1'b0;
                rel_cnt_reg <= 20'h0;
                if (instant || op_cnt_reg + 20'h1 >= op_target) begin
                    trip_reg <= 1'b1;
                    op_cnt_reg <= op_target;
                end else begin
                    op_cnt_reg <= op_cnt_reg + 20'h1;
                end
            end else begin
                // Blocking or pick-up loss both release here.
                trip_reg <= 1'b0;
                if (start_reg || releasing_reg) begin
                    // Start held over the release delay only with delayed release on.
                    start_reg <= ctrl_reg.delayed_release && !rel_expired;
                    if (rel_expired) begin
                        releasing_reg <= 1'b0;
                        rel_cnt_reg <= 20'h0;
                        op_cnt_reg <= 20'h0;
                    end else begin
                        releasing_reg <= 1'b1;
                        rel_cnt_reg <= rel_next;
                        // Timer cleared at once unless reset after release.
                        if (!ctrl_reg.reset_after_release) begin
                            op_cnt_reg <= 20'h0;
                        end else if (ctrl_reg.continue_timing && op_cnt_reg < op_target) begin
                            op_cnt_reg <= op_cnt_reg + 20'h1;
                        end
                    end
                end
            end
        end
    end

    // Forced status overrides the measured outputs.
    // Output forcing.
    always_comb begin
        case (force_mode)
            FORCE_START: out_next = '{start: 1'b1, trip: 1'b0, blocked: 1'b0};
            FORCE_TRIP: out_next = '{start: 1'b1, trip: 1'b1, blocked: 1'b0};
            FORCE_BLOCKED: out_next = '{start: 1'b0, trip: 1'b0, blocked: 1'b1};
            default: out_next = '{start: start_reg, trip: trip_reg, blocked: blocked_reg};
        endcase
    end
    assign stage_o = out_next;

    // Read data, valid in the cycle after the strobe.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= 32'h0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                OFS_CTRL: reg_rdata_o <= {16'h0, ctrl_reg};
                OFS_USET: reg_rdata_o <= {14'h0, uset_reg};
                OFS_DELAY: reg_rdata_o <= {12'h0, delay_ms_reg};
                OFS_DIAL: reg_rdata_o <= {16'h0, dial_reg};
                OFS_EXP: reg_rdata_o <= {16'h0, exp_reg};
                OFS_RELEASE: reg_rdata_o <= {12'h0, release_ms_reg};
                OFS_VT_PRIM: reg_rdata_o <= {8'h0, vt_prim_reg};
                OFS_STATUS: reg_rdata_o <= {24'h0, 3'(node_state), block_smp_reg, pickup, out_next};
                // Remaining time while timing, 5 ms units.
                OFS_REMAIN: reg_rdata_o <= (start_reg && !trip_reg) ? {12'h0, op_target - op_cnt_reg} : 32'h0;
                // Expected time follows the latest voltage in inverse mode.
                OFS_EXPECT: reg_rdata_o <= instant ? 32'h0 : {12'h0, op_target};
                OFS_RATIO0: reg_rdata_o <= {14'h0, ratio_reg[0]};
                8'h2c: reg_rdata_o <= {14'h0, ratio_reg[1]};
                8'h30: reg_rdata_o <= {14'h0, ratio_reg[2]};
                8'h34: reg_rdata_o <= {14'h0, ratio_reg[3]};
                OFS_PICKUP_PRIM: reg_rdata_o <= pickup_prim_reg;
                default: reg_rdata_o <= 32'h0;
            endcase
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_live_pick;
        tick && pickup && !blk_now && !off_mode;
    endsequence
    sequence s_drop;
        tick && !(pickup && !blk_now) && !off_mode && (start_reg || releasing_reg);
    endsequence

    tick_spacing_a: assert property (tick |=> !tick)
        else $error("Ticks too close.");
    start_on_pick_a: assert property (s_live_pick |=> start_reg)
        else $error("Start missing after pick-up.");
    blocked_only_a: assert property (tick && pickup && blk_now && !off_mode |=> blocked_reg && !trip_reg)
        else $error("Blocked pick-up misbehaved.");
    drop_now_a: assert property ((s_drop and !ctrl_reg.delayed_release) |=> !start_reg)
        else $error("Start not dropped at once.");
    hold_release_a: assert property ((s_drop and ctrl_reg.delayed_release && !rel_expired) |=> start_reg)
        else $error("Start not held in release.");
    instant_trip_a: assert property ((s_live_pick and instant) |=> trip_reg && start_reg)
        else $error("Instant trip missing.");
    early_trip_a: assert property ($rose(trip_reg) |-> op_cnt_reg == $past(op_target))
        else $error("Trip before delay.");
    timer_clear_a: assert property ((s_drop and !ctrl_reg.reset_after_release) |=> op_cnt_reg == 20'h0)
        else $error("Timer not cleared.");
    force_trip_a: assert property (force_mode == FORCE_TRIP |-> stage_o.trip && stage_o.start)
        else $error("Forced trip not shown.");
endmodule // overvoltage_stage_timing

`default_nettype wire

// ==== rtl/ovstage_pkg.sv ====
// Constants, register map and carrier types of the overvoltage stage timing block.
package ovstage_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_NS = 5000000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_MS = 5;
    localparam logic [19:0] MAX_TICKS = 20'h57e40;
    localparam logic [39:0] POW_CAP = 40'h0000ffffff;
    localparam logic [39:0] RESET_RATIO_PCT = 40'h61;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_USET = 8'h04;
    localparam logic [7:0] OFS_DELAY = 8'h08;
    localparam logic [7:0] OFS_DIAL = 8'h0c;
    localparam logic [7:0] OFS_EXP = 8'h10;
    localparam logic [7:0] OFS_RELEASE = 8'h14;
    localparam logic [7:0] OFS_VT_PRIM = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_REMAIN = 8'h20;
    localparam logic [7:0] OFS_EXPECT = 8'h24;
    localparam logic [7:0] OFS_RATIO0 = 8'h28;
    localparam logic [7:0] OFS_PICKUP_PRIM = 8'h38;
    localparam logic [15:0] CTRL_RESET = 16'h0030;
    localparam logic [17:0] USET_RESET = 18'h02904;
    localparam logic [19:0] DELAY_RESET = 20'h00028;
    localparam logic [15:0] DIAL_RESET = 16'h0005;
    localparam logic [15:0] EXP_RESET = 16'h0064;
    localparam logic [19:0] RELEASE_RESET = 20'h0003c;
    localparam logic [23:0] VT_PRIM_RESET = 24'h0000064;

    typedef enum {NODE_ON, NODE_BLOCKED, NODE_TEST, NODE_TEST_BLOCKED, NODE_OFF} node_state_t;
    typedef enum {FORCE_NORMAL, FORCE_START, FORCE_TRIP, FORCE_BLOCKED} force_t;
    typedef enum {ENG_IDLE, ENG_RATIO, ENG_PRIM, ENG_POWER, ENG_FRAC, ENG_TIME} eng_state_t;

    // Control word layout, high bit first.
    typedef struct packed {
        logic [4:0] spare;
        logic [1:0] force_sel;
        logic [1:0] op_mode;
        logic continue_timing;
        logic reset_after_release;
        logic delayed_release;
        logic inverse_delay_mode;
        logic [2:0] node_mode;
    } ctrl_t;

    // Stage outputs as seen by the trip logic.
    typedef struct packed {
        logic start;
        logic trip;
        logic blocked;
    } stage_out_t;
endpackage

// ==== verif/ovstage_far_end.sv ====
// Far-side model: measurement front end and blocking matrix feeding the stage.
`timescale 1ns/1ps
`default_nettype none
module ovstage_far_end (
    // Clock.
    input wire logic sys_clk_i,
    // Commands from the bench.
    input wire logic [17:0] level_i,
    input wire logic block_req_i,
    // Stage inputs.
    output logic [17:0] volt_o [4],
    output logic block_o
);
    // Phase 0 and the supervised channel follow the command; the others sit at nominal.
    // one phase over
    always_ff @(posedge sys_clk_i) begin
        volt_o[0] <= level_i;
        volt_o[1] <= 18'h02710;
        volt_o[2] <= 18'h02710;
        volt_o[3] <= level_i;
    end
    // Blocking reaches the stage one clock after the request, far inside the 5 ms margin.
    // early blocking delivery
    always_ff @(posedge sys_clk_i) begin
        block_o <= block_req_i;
    end
endmodule // ovstage_far_end
`default_nettype wire

// ==== verif/overvoltage_stage_timing_tb_top.sv ====
// Self-checking bench of the overvoltage stage timing block.
`timescale 1ns/1ps
`default_nettype none
module overvoltage_stage_timing_tb_top;
    import ovstage_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [17:0] volt [4];
    logic blk;
    logic [17:0] level = 18'h02710;
    logic block_req = 1'b0;
    stage_out_t stage_o;
    logic tick_o;
    int errors = 0;
    int comparisons = 0;
    int n;
    logic [31:0] d;
    logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h24, 8'hfc};
    logic [31:0] re [8] = '{32'h30, 32'h2904, 32'h28, 32'h5, 32'h64, 32'h3c, 32'h8, 32'h0};

    // Clock at 100 ns period.
    always #50 sys_clk_i = ~sys_clk_i;

    ovstage_far_end far_u (.sys_clk_i(sys_clk_i), .level_i(level), .block_req_i(block_req),
        .volt_o(volt), .block_o(blk));
    overvoltage_stage_timing #(.TICK_CYCLES(20)) dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .measured_voltage_i(volt), .block_i(blk), .stage_o(stage_o), .tick_o(tick_o));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask

    // Read data are taken in the cycle after the strobe; they stand until the next read strobe.
    task automatic rreg(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    // Waits for k processing ticks, then lets the stage outputs settle.
    task automatic tk(input int k);
        repeat (k) @(posedge sys_clk_i iff tick_o === 1'b1);
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic fault(input logic [17:0] v);
        @(posedge sys_clk_i);
        level <= v;
        n = 0;
        while (stage_o.start !== 1'b1 && n < 20) begin
            tk(1);
            n++;
        end
    endtask

    task automatic conclude();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog well past the expected run of a few dozen ticks.
    initial begin
        #1ms;
        errors++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        #1 chk("stage after reset", 3'b000, stage_o);
        // Reset values of six settings and the expected time, plus an unmapped place.
        for (int i = 0; i < 8; i++) begin
            rreg(ra[i], d);
            chk("reset reg", re[i], d);
        end
        // One processing tick every TICK_CYCLES clocks.
        @(posedge sys_clk_i iff tick_o === 1'b1);
        n = 1;
        while (n < 40) begin
            @(posedge sys_clk_i);
            if (tick_o === 1'b1) break;
            n++;
        end
        chk("tick period", 32'd20, n);
        // Fixed delay of 40 ms counted in ticks from start to trip.
        fault(18'h02af8);
        chk("start", 1'b1, stage_o.start);
        rreg(OFS_REMAIN, d);
        chk("remaining", 32'd7, d);
        n = 0;
        while (stage_o.trip !== 1'b1 && n < 20) begin
            tk(1);
            n++;
        end
        chk("fixed ticks", 32'd7, n);
        rreg(OFS_RATIO0, d);
        chk("ratio phase 0", 32'd104, d);
        rreg(8'h2c, d);
        chk("ratio phase 1", 32'd95, d);
        rreg(8'h34, d);
        chk("ratio supervised", 32'd104, d);
        rreg(OFS_PICKUP_PRIM, d);
        chk("pick-up primary", 32'd105, d);
        // Inside the 97 percent band pick-up holds.
        level <= 18'h0283c;
        tk(2);
        rreg(OFS_STATUS, d);
        chk("hysteresis", 1'b1, d[3]);
        // Delayed release holds start for 12 ticks after pick-up drops.
        level <= 18'h02328;
        tk(6);
        chk("start held", 1'b1, stage_o.start);
        tk(10);
        chk("start dropped", 1'b0, stage_o.start);
        // Zero delay trips together with start.
        wreg(OFS_DELAY, 32'h0);
        rreg(OFS_EXPECT, d);
        chk("instant expected", 32'h0, d);
        fault(18'h02af8);
        chk("instant trip", 1'b1, stage_o.trip);
        // Without delayed release start follows pick-up at once.
        wreg(OFS_CTRL, 32'h60);
        level <= 18'h02328;
        tk(3);
        chk("fast drop", 1'b0, stage_o.start);
        // Blocking active when pick-up comes gives blocked only.
        block_req <= 1'b1;
        level <= 18'h02af8;
        tk(3);
        chk("blocked stage", 3'b001, stage_o);
        rreg(OFS_STATUS, d);
        chk("status blocked", 3'b001, d[2:0]);
        chk("status pick-up and block", 2'b11, d[4:3]);
        // Forcing trip and then turning the node off.
        wreg(OFS_CTRL, 32'h470);
        tk(1);
        chk("forced trip", 1'b1, stage_o.trip);
        // Inverse time: dial 0.05 s over ratio 1.42 less one is 24 ticks, over 1.04 less one 250.
        block_req <= 1'b0;
        wreg(OFS_CTRL, 32'h38);
        level <= 18'h03a98;
        tk(2);
        rreg(OFS_EXPECT, d);
        chk("inverse ticks high", 32'd24, d);
        level <= 18'h02af8;
        tk(2);
        rreg(OFS_EXPECT, d);
        chk("inverse ticks low", 32'd250, d);
        wreg(OFS_CTRL, 32'h74);
        tk(3);
        chk("node off", 3'b000, stage_o);
        rreg(OFS_STATUS, d);
        chk("off state", 32'h4, d[7:5]);
        // Two-voltage mode ignores a single phase over threshold.
        wreg(OFS_CTRL, 32'h100);
        tk(3);
        chk("two phase mode", 3'b000, stage_o);
        conclude();
    end
endmodule // overvoltage_stage_timing_tb_top
`default_nettype wire
